// *** logic/pcr_config_regs.v ***
// Overview of operation
// - Format 0 moves payload through the FIFO path.
// - Format 1 is synchronous serial, transmit data from general pin zero.
// - Format 2 transmits PN9 data; receive acts as format 0.
// - Format 3 is asynchronous serial: data in on pin zero, out on output pin.
// - CRC enable, reset 1, turns CRC on for transmit and receive in formats 0 and 2.
// - Length mode 0: fixed length from the payload size register.
// - Length mode 1, reset value: length from first byte after sync.
// - Length mode 2 is unbounded; mode 3 is reserved, refuses every length and sets status bit 24.
// - Received address filtered against node id, reset 0; 0x00/0xFF broadcast.
// - Frequency adds channel number times channel spacing to base word.
// - In receive, IF code times fxosc/1024 is subtracted; reset 15.
// - Signed offset in fxosc/16384 steps added to base; reset 0.
// - Top two bits of the base word read zero and ignore writes.
// - 24-bit base word in fxosc/65536 steps, reset 0x1E/0xC4/0xEC.
// - In variable mode the payload size is the largest accepted length.
// - Filter mode: none, exact, plus 0x00, plus 0x00 and 0xFF.
//
// The APB slave port is this design's own decision.
`include "pcr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pcr_config_regs #(
  parameter ADDR_W = 8,
  parameter [15:0] SPACING_RST = 16'h0100
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire bit_tick,
  input wire frame_start,
  input wire rx_mode,
  input wire tx_fifo_bit,
  input wire rx_demod_bit,
  input wire general_pin_zero,
  input wire addr_valid,
  input wire [7:0] rx_addr,
  input wire len_valid,
  input wire [7:0] rx_len,
  output reg tx_mod_bit_r,
  output reg rx_data_bit_r,
  output reg serial_data_out_r,
  output reg fifo_path_en_r,
  output reg serial_mode_r,
  output reg crc_en_r,
  output reg len_fixed_r,
  output reg len_variable_r,
  output reg len_infinite_r,
  output reg [7:0] payload_limit_r,
  output reg addr_accept_r,
  output reg addr_reject_r,
  output reg len_ok_r,
  output reg len_bad_r,
  output reg [23:0] synth_word_r
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Register hit at a word index; unaligned addresses never hit
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [7:0] idx;
    begin
      addr_hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    end
  endfunction

  // PN9 step, x^9 + x^5 + 1
  function [8:0] pn9_next;
    input [8:0] s;
    begin
      pn9_next = {s[0] ^ s[5], s[8:1]};
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg whiten_r;
  reg [1:0] payload_path_select_r;
  reg crc_r;
  reg [1:0] len_cfg_r;
  reg [7:0] node_id_r;
  reg [7:0] hop_index_r;
  reg [4:0] intermediate_tuning_code_r;
  reg [7:0] synth_offset_trim_r;
  reg [5:0] tune_hi_r;
  reg [7:0] tune_mid_r;
  reg [7:0] tune_lo_r;
  reg [7:0] payload_size_r;
  reg [1:0] node_filter_mode_r;
  reg [15:0] spacing_r;
  reg pin_s1_r;
  reg pin_s2_r;
  reg [8:0] pn9_r;
  reg [8:0] wtx_r;
  reg [8:0] wrx_r;

  wire wr_en;
  wire [7:0] wb;
  wire lane0;
  wire lane1;
  wire hit_any;

  // Write commits only at the access edge that sees pready high
  assign wr_en = psel & penable & pwrite & pready;
  assign wb = pwdata[7:0];
  assign lane0 = pstrb[0];
  assign lane1 = pstrb[1];
  assign hit_any = addr_hit(paddr, `PCR_IDX_PKT_CTRL) | addr_hit(paddr, `PCR_IDX_NODE_ID) |
    addr_hit(paddr, `PCR_IDX_HOP) | addr_hit(paddr, `PCR_IDX_IF) |
    addr_hit(paddr, `PCR_IDX_OFFSET) | addr_hit(paddr, `PCR_IDX_TUNE_HI) |
    addr_hit(paddr, `PCR_IDX_TUNE_MID) | addr_hit(paddr, `PCR_IDX_TUNE_LO) |
    addr_hit(paddr, `PCR_IDX_PAYLOAD) | addr_hit(paddr, `PCR_IDX_FILTER) |
    addr_hit(paddr, `PCR_IDX_SPACING) | addr_hit(paddr, `PCR_IDX_STATUS);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Byte lane 0 carries every 8-bit register; reserved bits are not stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      whiten_r <= `PCR_RST_WHITEN;
      payload_path_select_r <= `PCR_RST_FMT;
      crc_r <= `PCR_RST_CRC;
      len_cfg_r <= `PCR_RST_LEN;
      node_id_r <= `PCR_RST_NODE_ID;
      hop_index_r <= `PCR_RST_HOP;
      intermediate_tuning_code_r <= `PCR_RST_IF;
      synth_offset_trim_r <= `PCR_RST_OFFSET;
      tune_hi_r <= `PCR_RST_TUNE_HI;
      tune_mid_r <= `PCR_RST_TUNE_MID;
      tune_lo_r <= `PCR_RST_TUNE_LO;
      payload_size_r <= `PCR_RST_PAYLOAD;
      node_filter_mode_r <= `PCR_RST_FILTER;
      spacing_r <= SPACING_RST; // Parameter default, a constant
    end else if (wr_en && lane0) begin
      if (addr_hit(paddr, `PCR_IDX_PKT_CTRL)) begin
        whiten_r <= wb[`PCR_POS_WHITEN];
        payload_path_select_r <= wb[`PCR_POS_FMT+1:`PCR_POS_FMT];
        crc_r <= wb[`PCR_POS_CRC];
        len_cfg_r <= wb[`PCR_POS_LEN+1:`PCR_POS_LEN];
      end
      if (addr_hit(paddr, `PCR_IDX_NODE_ID)) node_id_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_HOP)) hop_index_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_IF)) intermediate_tuning_code_r <= wb[4:0];
      if (addr_hit(paddr, `PCR_IDX_OFFSET)) synth_offset_trim_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_TUNE_HI)) tune_hi_r <= wb[5:0];
      if (addr_hit(paddr, `PCR_IDX_TUNE_MID)) tune_mid_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_TUNE_LO)) tune_lo_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_PAYLOAD)) payload_size_r <= wb;
      if (addr_hit(paddr, `PCR_IDX_FILTER)) node_filter_mode_r <= wb[1:0];
      if (addr_hit(paddr, `PCR_IDX_SPACING)) begin
        spacing_r[7:0] <= wb;
        if (lane1) begin
          spacing_r[15:8] <= pwdata[15:8];
        end
      end
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  reg [31:0] rd_nxt;

  // Read mux; reserved bits and the top two base bits read zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (1'b1)
      addr_hit(paddr, `PCR_IDX_PKT_CTRL): begin
        rd_nxt[7:0] = {1'b0, whiten_r, payload_path_select_r, 1'b0, crc_r, len_cfg_r};
      end
      addr_hit(paddr, `PCR_IDX_NODE_ID): begin
        rd_nxt[7:0] = node_id_r;
      end
      addr_hit(paddr, `PCR_IDX_HOP): begin
        rd_nxt[7:0] = hop_index_r;
      end
      addr_hit(paddr, `PCR_IDX_IF): begin
        rd_nxt[7:0] = {3'h0, intermediate_tuning_code_r};
      end
      addr_hit(paddr, `PCR_IDX_OFFSET): begin
        rd_nxt[7:0] = synth_offset_trim_r;
      end
      addr_hit(paddr, `PCR_IDX_TUNE_HI): begin
        rd_nxt[7:0] = {2'h0, tune_hi_r};
      end
      addr_hit(paddr, `PCR_IDX_TUNE_MID): begin
        rd_nxt[7:0] = tune_mid_r;
      end
      addr_hit(paddr, `PCR_IDX_TUNE_LO): begin
        rd_nxt[7:0] = tune_lo_r;
      end
      addr_hit(paddr, `PCR_IDX_PAYLOAD): begin
        rd_nxt[7:0] = payload_size_r;
      end
      addr_hit(paddr, `PCR_IDX_FILTER): begin
        rd_nxt[7:0] = {6'h00, node_filter_mode_r};
      end
      addr_hit(paddr, `PCR_IDX_SPACING): begin
        rd_nxt[15:0] = spacing_r;
      end
      addr_hit(paddr, `PCR_IDX_STATUS): begin
        rd_nxt[23:0] = synth_word_r;
        rd_nxt[`PCR_POS_STAT_LRES] = (len_cfg_r == `PCR_LEN_RSVD);
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // No wait state: answer built in setup, pready high for the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        pslverr <= ~hit_any | (pwrite & addr_hit(paddr, `PCR_IDX_STATUS));
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin synchroniser and sequence generators
  // ----------------------------------------
  // Pin zero is asynchronous; only the second stage is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= general_pin_zero;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Random data and both whitening sequences restart at each frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pn9_r <= `PCR_RST_PN9;
      wtx_r <= `PCR_RST_PN9;
      wrx_r <= `PCR_RST_PN9;
    end else if (frame_start) begin
      pn9_r <= `PCR_RST_PN9;
      wtx_r <= `PCR_RST_PN9;
      wrx_r <= `PCR_RST_PN9;
    end else if (bit_tick) begin
      pn9_r <= pn9_next(pn9_r);
      wtx_r <= pn9_next(wtx_r);
      wrx_r <= pn9_next(wrx_r);
    end
  end

  // ----------------------------------------
  // Data path selection
  // ----------------------------------------
  wire packet_fmt;
  reg tx_src;

  // Whitening only makes sense where the block frames packets
  assign packet_fmt = (payload_path_select_r == `PCR_FMT_FIFO) ||
    (payload_path_select_r == `PCR_FMT_PN9);

  always @* begin
    case (payload_path_select_r)
      `PCR_FMT_FIFO: tx_src = tx_fifo_bit ^ (whiten_r & wtx_r[0]);
      `PCR_FMT_SYNC: tx_src = pin_s2_r;
      `PCR_FMT_PN9: tx_src = pn9_r[0];
      `PCR_FMT_ASYNC: tx_src = pin_s2_r;
      default: tx_src = tx_fifo_bit;
    endcase
  end

  // Random mode receives like FIFO mode; serial modes mirror rx on the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mod_bit_r <= 1'b0;
      rx_data_bit_r <= 1'b0;
      serial_data_out_r <= 1'b0;
    end else begin
      tx_mod_bit_r <= tx_src;
      rx_data_bit_r <= rx_demod_bit ^ (whiten_r & packet_fmt & wrx_r[0]);
      serial_data_out_r <= ~packet_fmt & rx_demod_bit;
    end
  end

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  // Reserved length code enables no length mode at all
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_path_en_r <= 1'b1;
      serial_mode_r <= 1'b0;
      crc_en_r <= 1'b1;
      len_fixed_r <= 1'b0;
      len_variable_r <= 1'b1;
      len_infinite_r <= 1'b0;
      payload_limit_r <= `PCR_RST_PAYLOAD;
    end else begin
      fifo_path_en_r <= packet_fmt;
      serial_mode_r <= ~packet_fmt;
      crc_en_r <= crc_r & packet_fmt;
      len_fixed_r <= (len_cfg_r == `PCR_LEN_FIXED);
      len_variable_r <= (len_cfg_r == `PCR_LEN_VAR);
      len_infinite_r <= (len_cfg_r == `PCR_LEN_INF);
      payload_limit_r <= payload_size_r;
    end
  end

  // ----------------------------------------
  // Address filter and length check
  // ----------------------------------------
  reg addr_pass;

  always @* begin
    case (node_filter_mode_r)
      `PCR_FLT_NONE: addr_pass = 1'b1;
      `PCR_FLT_EXACT: addr_pass = (rx_addr == node_id_r);
      `PCR_FLT_BC0: addr_pass = (rx_addr == node_id_r) | (rx_addr == 8'h00);
      `PCR_FLT_BC0FF: addr_pass = (rx_addr == node_id_r) | (rx_addr == 8'h00) |
        (rx_addr == 8'hFF);
      default: addr_pass = 1'b0;
    endcase
  end

  reg len_pass;

  always @* begin
    case (len_cfg_r)
      `PCR_LEN_FIXED: len_pass = 1'b1;
      `PCR_LEN_VAR: len_pass = (rx_len <= payload_size_r);
      `PCR_LEN_INF: len_pass = 1'b1;
      default: len_pass = 1'b0;
    endcase
  end

  // One-cycle verdicts, one cycle after the strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_accept_r <= 1'b0;
      addr_reject_r <= 1'b0;
      len_ok_r <= 1'b0;
      len_bad_r <= 1'b0;
    end else begin
      addr_accept_r <= addr_valid & addr_pass;
      addr_reject_r <= addr_valid & ~addr_pass;
      len_ok_r <= len_valid & len_pass;
      len_bad_r <= len_valid & ~len_pass;
    end
  end

  // ----------------------------------------
  // Synthesizer word
  // ----------------------------------------
  // All terms in fxosc/65536 units; wraps modulo 2^24
  wire [23:0] base_word;
  wire [23:0] hop_term;
  wire [25:0] off_term;
  wire [25:0] if_term;
  wire [25:0] synth_sum;

  assign base_word = {2'h0, tune_hi_r, tune_mid_r, tune_lo_r};
  assign hop_term = hop_index_r * spacing_r;
  assign off_term = {{16{synth_offset_trim_r[7]}}, synth_offset_trim_r, 2'h0};
  assign if_term = rx_mode ? {15'h0000, intermediate_tuning_code_r, 6'h00} : 26'h0000000;
  assign synth_sum = {2'h0, base_word} + {2'h0, hop_term} + off_term - if_term;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_word_r <= 24'h000000;
    end else begin
      synth_word_r <= synth_sum[23:0];
    end
  end

endmodule

`default_nettype wire

// *** logic/pcr_defines.vh ***
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PCR_IDX_PKT_CTRL 8'h08
`define PCR_IDX_NODE_ID 8'h09
`define PCR_IDX_HOP 8'h0A
`define PCR_IDX_IF 8'h0B
`define PCR_IDX_OFFSET 8'h0C
`define PCR_IDX_TUNE_HI 8'h0D
`define PCR_IDX_TUNE_MID 8'h0E
`define PCR_IDX_TUNE_LO 8'h0F
`define PCR_IDX_PAYLOAD 8'h20
`define PCR_IDX_FILTER 8'h21
`define PCR_IDX_SPACING 8'h22
`define PCR_IDX_STATUS 8'h23

// ----------------------------------------
// Field positions in the packet control and status registers
// ----------------------------------------
`define PCR_POS_WHITEN 6
`define PCR_POS_FMT 4
`define PCR_POS_CRC 2
`define PCR_POS_LEN 0
`define PCR_POS_STAT_LRES 24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCR_RST_WHITEN 1'b1
`define PCR_RST_FMT 2'h0
`define PCR_RST_CRC 1'b1
`define PCR_RST_LEN 2'h1
`define PCR_RST_NODE_ID 8'h00
`define PCR_RST_HOP 8'h00
`define PCR_RST_IF 5'h0F
`define PCR_RST_OFFSET 8'h00
`define PCR_RST_TUNE_HI 6'h1E
`define PCR_RST_TUNE_MID 8'hC4
`define PCR_RST_TUNE_LO 8'hEC
`define PCR_RST_PAYLOAD 8'hFF
`define PCR_RST_FILTER 2'h0
`define PCR_RST_PN9 9'h1FF

// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define PCR_FMT_FIFO 2'h0
`define PCR_FMT_SYNC 2'h1
`define PCR_FMT_PN9 2'h2
`define PCR_FMT_ASYNC 2'h3
`define PCR_LEN_FIXED 2'h0
`define PCR_LEN_VAR 2'h1
`define PCR_LEN_INF 2'h2
`define PCR_LEN_RSVD 2'h3
`define PCR_FLT_NONE 2'h0
`define PCR_FLT_EXACT 2'h1
`define PCR_FLT_BC0 2'h2
`define PCR_FLT_BC0FF 2'h3

// ----------------------------------------
// Frequency scaling shifts to the base-word unit of fxosc/65536
// ----------------------------------------
`define PCR_IF_SHIFT 6
`define PCR_OFF_SHIFT 2

`endif

// *** verification/pcr_config_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker for the configuration slice
// ----------------------------------------
module pcr_config_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_demod_bit,
  input wire logic addr_valid,
  input wire logic len_valid,
  input wire logic [7:0] rx_len,
  input wire logic serial_data_out_r,
  input wire logic fifo_path_en_r,
  input wire logic serial_mode_r,
  input wire logic crc_en_r,
  input wire logic len_fixed_r,
  input wire logic len_variable_r,
  input wire logic len_infinite_r,
  input wire logic [7:0] payload_limit_r,
  input wire logic addr_accept_r,
  input wire logic addr_reject_r,
  input wire logic len_ok_r,
  input wire logic len_bad_r
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answers one cycle after setup and only for one cycle
  AST_SETUP_READY: assert property (psel && !penable |=> pready && psel && penable)
    else $error("no ready one cycle after setup");
  AST_READY_PULSE: assert property (pready |=> !pready ##1 (pready == $past(psel && !penable)))
    else $error("ready held too long");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Path selection is never both packet and serial
  AST_PATH_EXCL: assert property (fifo_path_en_r != serial_mode_r)
    else $error("path flags not exclusive");
  AST_CRC_GATE: assert property (crc_en_r |-> fifo_path_en_r)
    else $error("crc active in serial format");
  AST_LEN_ONEHOT: assert property ($onehot0({len_fixed_r, len_variable_r, len_infinite_r}))
    else $error("length modes overlap");
  // Mode checks guarded against a mode change in flight
  AST_FIXED_OK: assert property (len_valid && len_fixed_r ##1 len_fixed_r |-> len_ok_r)
    else $error("fixed length refused");
  AST_VAR_LIMIT: assert property (len_valid && len_variable_r && rx_len > payload_limit_r
    ##1 len_variable_r && $stable(payload_limit_r) |-> len_bad_r && !len_ok_r)
    else $error("oversize length accepted");
  AST_ADDR_VERDICT: assert property (addr_valid |=> addr_accept_r != addr_reject_r)
    else $error("address verdict missing");
  AST_ADDR_QUIET: assert property (!addr_valid |=> !addr_accept_r && !addr_reject_r)
    else $error("address verdict without byte");
  AST_SERIAL_ECHO: assert property (serial_mode_r && $past(serial_mode_r)
    |-> serial_data_out_r == $past(rx_demod_bit))
    else $error("serial output not echoing data");
endmodule

bind pcr_config_regs pcr_config_regs_chk u_pcr_config_regs_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .rx_demod_bit(rx_demod_bit), .addr_valid(addr_valid),
  .len_valid(len_valid), .rx_len(rx_len), .serial_data_out_r(serial_data_out_r),
  .fifo_path_en_r(fifo_path_en_r), .serial_mode_r(serial_mode_r), .crc_en_r(crc_en_r),
  .len_fixed_r(len_fixed_r), .len_variable_r(len_variable_r),
  .len_infinite_r(len_infinite_r), .payload_limit_r(payload_limit_r),
  .addr_accept_r(addr_accept_r), .addr_reject_r(addr_reject_r), .len_ok_r(len_ok_r),
  .len_bad_r(len_bad_r)
);

`default_nettype wire

// *** verification/tb_pcr_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_pcr_config_regs;
  localparam logic [7:0] a_pkt = 8'h20, a_node = 8'h24, a_hop = 8'h28, a_if = 8'h2C;
  localparam logic [7:0] a_off = 8'h30, a_hi = 8'h34, a_mid = 8'h38, a_lo = 8'h3C;
  localparam logic [7:0] a_pay = 8'h80, a_flt = 8'h84, a_spc = 8'h88, a_stat = 8'h8C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic bit_tick, frame_start, rx_mode, tx_fifo_bit, rx_demod_bit, general_pin_zero;
  logic addr_valid, len_valid, tx_mod_bit_r, rx_data_bit_r, serial_data_out_r;
  logic fifo_path_en_r, serial_mode_r, crc_en_r, len_fixed_r, len_variable_r;
  logic len_infinite_r, addr_accept_r, addr_reject_r, len_ok_r, len_bad_r;
  logic [7:0] paddr, rx_addr, rx_len, payload_limit_r;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [23:0] synth_word_r;
  int miscompares, comparisons, cycles;

  pcr_config_regs u_pcr_config_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_tick(bit_tick), .frame_start(frame_start), .rx_mode(rx_mode),
    .tx_fifo_bit(tx_fifo_bit), .rx_demod_bit(rx_demod_bit),
    .general_pin_zero(general_pin_zero), .addr_valid(addr_valid), .rx_addr(rx_addr),
    .len_valid(len_valid), .rx_len(rx_len), .tx_mod_bit_r(tx_mod_bit_r),
    .rx_data_bit_r(rx_data_bit_r), .serial_data_out_r(serial_data_out_r),
    .fifo_path_en_r(fifo_path_en_r), .serial_mode_r(serial_mode_r), .crc_en_r(crc_en_r),
    .len_fixed_r(len_fixed_r), .len_variable_r(len_variable_r),
    .len_infinite_r(len_infinite_r), .payload_limit_r(payload_limit_r),
    .addr_accept_r(addr_accept_r), .addr_reject_r(addr_reject_r), .len_ok_r(len_ok_r),
    .len_bad_r(len_bad_r), .synth_word_r(synth_word_r)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Run needs about 250 cycles; five thousand means a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask

  // Strobe a byte in for one cycle, then look at the verdict pair
  task automatic probe(input logic is_len, input logic [7:0] v, input logic good);
    @(posedge pclk);
    addr_valid <= !is_len;
    len_valid <= is_len;
    rx_addr <= v;
    rx_len <= v;
    @(posedge pclk);
    addr_valid <= 1'b0;
    len_valid <= 1'b0;
    #1;
    chk(is_len ? {len_ok_r, len_bad_r} : {addr_accept_r, addr_reject_r}, {good, !good});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, bit_tick, frame_start, rx_mode} = 7'h00;
    {tx_fifo_bit, rx_demod_bit, general_pin_zero, addr_valid, len_valid} = 5'h00;
    {paddr, rx_addr, rx_len, pwdata, pstrb} = 60'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values across the table
    rdchk(a_pkt, 32'h45);
    rdchk(a_node, 32'h00);
    rdchk(a_hop, 32'h00);
    rdchk(a_if, 32'h0F);
    rdchk(a_off, 32'h00);
    rdchk(a_hi, 32'h1E);
    rdchk(a_mid, 32'hC4);
    rdchk(a_lo, 32'hEC);
    rdchk(a_pay, 32'hFF);
    rdchk(a_flt, 32'h00);
    chk(synth_word_r, 32'h1EC4EC);
    // Reserved and read-only bits ignore writes
    wr(a_pkt, 32'hFE);
    rdchk(a_pkt, 32'h76);
    wr(a_if, 32'hFF);
    rdchk(a_if, 32'h1F);
    wr(a_hi, 32'hFF);
    rdchk(a_hi, 32'h3F);
    wr(a_hi, 32'h1E);
    wr(a_if, 32'h0F);
    // Write without lane zero strobe is dropped
    xfer(1'b1, a_node, 32'h77, 4'h0);
    rdchk(a_node, 32'h00);
    // Refusals: unmapped, unaligned, read-only status
    xfer(1'b0, 8'h40, 32'h0, 4'hF);
    chk(err, 1'b1);
    xfer(1'b0, 8'h21, 32'h0, 4'hF);
    chk(err, 1'b1);
    xfer(1'b1, a_stat, 32'h0, 4'hF);
    chk(err, 1'b1);
    // Each format with a legal length mode, whitening off; code 3 never written
    for (int f = 0; f < 4; f++) begin
      wr(a_pkt, 32'(f * 16 + 4 + f % 3));
      @(posedge pclk);
      rx_demod_bit <= 1'b1;
      general_pin_zero <= 1'b1;
      settle(5);
      chk(fifo_path_en_r, f == 0 || f == 2);
      chk(serial_mode_r, f[0]);
      chk(crc_en_r, !f[0]);
      chk({len_fixed_r, len_variable_r, len_infinite_r}, 3'd4 >> (f % 3));
      chk(serial_data_out_r, f[0]);
      chk(tx_mod_bit_r, f != 0);
      @(posedge pclk);
      rx_demod_bit <= 1'b0;
      general_pin_zero <= 1'b0;
    end
    // Whitening on: seed low bit inverts both directions
    wr(a_pkt, 32'h45);
    @(posedge pclk);
    rx_demod_bit <= 1'b1;
    settle(3);
    chk({tx_mod_bit_r, rx_data_bit_r}, 2'b10);
    // Nine steps bring a zero to the low bit; frame start restores the seed
    repeat (9) begin
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
    end
    settle(2);
    chk({tx_mod_bit_r, rx_data_bit_r}, 2'b01);
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    settle(2);
    chk({tx_mod_bit_r, rx_data_bit_r}, 2'b10);
    // Filter modes against node id and both broadcast values
    wr(a_node, 32'h5A);
    for (int m = 0; m < 4; m++) begin
      wr(a_flt, 32'(m));
      probe(1'b0, 8'h5A, 1'b1);
      probe(1'b0, 8'h00, m != 1);
      probe(1'b0, 8'hFF, m == 0 || m == 3);
      probe(1'b0, 8'h33, m == 0);
    end
    // Length checks at the limit and beyond
    wr(a_pay, 32'h10);
    wr(a_pkt, 32'h05);
    probe(1'b1, 8'h10, 1'b1);
    chk(payload_limit_r, 32'h10);
    probe(1'b1, 8'h11, 1'b0);
    wr(a_pkt, 32'h04);
    probe(1'b1, 8'h11, 1'b1);
    wr(a_pkt, 32'h06);
    probe(1'b1, 8'hFF, 1'b1);
    probe(1'b1, 8'h00, 1'b1);
    wr(a_pkt, 32'h05);
    // Synthesizer word: channel, negative offset, receive IF, spacing
    wr(a_hop, 32'h03);
    wr(a_off, 32'hFE);
    settle(3);
    chk(synth_word_r, 32'h1EC7E4);
    @(posedge pclk);
    rx_mode <= 1'b1;
    settle(3);
    chk(synth_word_r, 32'h1EC424);
    wr(a_spc, 32'h0200);
    rdchk(a_stat, 32'h1EC724);
    wrap_up();
  end
endmodule

`default_nettype wire
